// ==== verilog/branch_or_shift_exec_unit.sv ====
`timescale 1ns/10ps
module branch_or_shift_exec_unit
(
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                reset,
    input  wire logic                                clkEn,
    // apb slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [branch_shift_pkg::ADDR_W-1:0] paddr,
    input  wire logic [branch_shift_pkg::DATA_W-1:0] pwdata,
    output logic      [branch_shift_pkg::DATA_W-1:0] prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // core state
    output logic      [branch_shift_pkg::PC_W-1:0]   progCounter,
    output logic      [branch_shift_pkg::BYTE_W-1:0] accumulator,
    output logic                                     resultNullFlag,
    output logic                                     shiftOutFlag,
    output logic                                     execBusy
);
    typedef enum logic {EXEC_IDLE, EXEC_JUMP_LOAD} exec_state_e;

    exec_state_e                              state_ff;
    exec_state_e                              nxt_state;
    logic [branch_shift_pkg::BYTE_W-1:0]      acc_ff;
    logic [branch_shift_pkg::BYTE_W-1:0]      nxt_acc;
    logic [branch_shift_pkg::LATCH_W-1:0]     latch_ff;
    logic [branch_shift_pkg::LATCH_W-1:0]     nxt_latch;
    logic [branch_shift_pkg::IDX_W-1:0]       fileIdx_ff;
    logic [branch_shift_pkg::IDX_W-1:0]       nxt_fileIdx;
    logic [branch_shift_pkg::INSTR_W-1:0]     instr_ff;
    logic [branch_shift_pkg::INSTR_W-1:0]     nxt_instr;
    logic [branch_shift_pkg::PC_W-1:0]        jumpTarget_ff;
    logic [branch_shift_pkg::PC_W-1:0]        nxt_jumpTarget;
    logic                                     null_ff;
    logic                                     nxt_null;
    logic                                     shift_ff;
    logic                                     nxt_shift;
    logic                                     busy_ff;
    logic                                     nxt_busy;
    logic [branch_shift_pkg::BYTE_W-1:0]      file_ff [branch_shift_pkg::FILE_DEPTH];
    logic                                     fileWe;
    logic [branch_shift_pkg::IDX_W-1:0]       fileWeIdx;
    logic [branch_shift_pkg::BYTE_W-1:0]      fileWeData;
    logic [branch_shift_pkg::DATA_W-1:0]      prdata_ff;
    logic [branch_shift_pkg::DATA_W-1:0]      nxt_prdata;
    logic                                     pready_ff;
    logic                                     nxt_pready;
    logic                                     pslverr_ff;
    logic                                     nxt_pslverr;

    // decoded apb and instruction fields
    logic                                     wrDone;
    logic                                     mapped;
    logic [branch_shift_pkg::OPC_W-1:0]       opcode;
    logic                                     opcodeLegal;
    logic                                     target;
    logic [branch_shift_pkg::LIT_W-1:0]       literal11;
    logic [branch_shift_pkg::IDX_W-1:0]       instrIdx;
    logic                                     launch;
    logic                                     launchJump;
    logic                                     launchOne;
    logic [branch_shift_pkg::BYTE_W-1:0]      operand;
    logic [branch_shift_pkg::BYTE_W-1:0]      aluResult;
    logic                                     aluZero;
    logic                                     aluShift;
    logic                                     isShift;
    logic                                     toFile;
    logic [branch_shift_pkg::DATA_W-1:0]      readMux;
    logic [branch_shift_pkg::PC_W-1:0]        pcValue;

    // a write only takes effect at the access edge where pready is already high
    assign wrDone = psel & penable & pready_ff & pwrite;

    assign opcode    = pwdata[branch_shift_pkg::INSTR_OPC_LSB +: branch_shift_pkg::OPC_W];
    assign target    = pwdata[branch_shift_pkg::INSTR_TGT_BIT];
    assign literal11 = pwdata[branch_shift_pkg::INSTR_LIT_LSB +: branch_shift_pkg::LIT_W];
    assign instrIdx  = pwdata[branch_shift_pkg::INSTR_LIT_LSB +: branch_shift_pkg::IDX_W];
    assign opcodeLegal = (opcode <= branch_shift_pkg::OPC_SHR);

    assign launch     = wrDone & (paddr == branch_shift_pkg::OFF_INSTR) & opcodeLegal;
    assign launchJump = launch & (opcode == branch_shift_pkg::OPC_JUMP);
    assign launchOne  = launch & (opcode != branch_shift_pkg::OPC_JUMP);
    assign isShift    = (opcode == branch_shift_pkg::OPC_SHL) |
                        (opcode == branch_shift_pkg::OPC_SHR);
    // or-literal always lands in the accumulator, whatever the target bit says
    assign toFile     = (opcode != branch_shift_pkg::OPC_OR_LIT) &
                        (target == branch_shift_pkg::TGT_FILE);
    assign operand    = file_ff[instrIdx];

    exec_alu u_alu
    (
        .opcode     (opcode),
        .accIn      (acc_ff),
        .fileIn     (operand),
        .literal    (pwdata[7:0]),
        .result     (aluResult),
        .resultZero (aluZero),
        .shiftBit   (aluShift)
    );

    prog_counter_unit u_pc
    (
        .ref_clk    (ref_clk),
        .reset      (reset),
        .clkEn      (clkEn),
        .advance    (launchOne),                                              // [RL10]
        .load       (state_ff == EXEC_JUMP_LOAD),                             // [RL3]
        .loadValue  (jumpTarget_ff),
        .pc_ff      (pcValue)
    );

    // execution sequencing
    always_comb
    begin
        nxt_state      = state_ff;
        nxt_jumpTarget = jumpTarget_ff;
        unique case (state_ff)
            EXEC_IDLE:
            begin
                if (launchJump)
                begin
                    nxt_jumpTarget = {latch_ff[branch_shift_pkg::LATCH_JUMP_MSB:
                                               branch_shift_pkg::LATCH_JUMP_LSB],  // [RL2]
                                      literal11};                                 // [RL1]
                    nxt_state      = EXEC_JUMP_LOAD;                              // [RL3]
                end
            end
            EXEC_JUMP_LOAD:
            begin
                nxt_state = EXEC_IDLE;
            end
        endcase
        nxt_busy = (nxt_state == EXEC_JUMP_LOAD);
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff      <= EXEC_IDLE;
            jumpTarget_ff <= branch_shift_pkg::RST_PC;
            busy_ff       <= 1'b0;
        end
        else if (clkEn)
        begin
            state_ff      <= nxt_state;
            jumpTarget_ff <= nxt_jumpTarget;
            busy_ff       <= nxt_busy;
        end
    end

    // accumulator, latch, index, instruction and flags
    always_comb
    begin
        nxt_acc     = acc_ff;
        nxt_latch   = latch_ff;
        nxt_fileIdx = fileIdx_ff;
        nxt_instr   = instr_ff;
        nxt_null    = null_ff;
        nxt_shift   = shift_ff;
        if (wrDone)
        begin
            unique case (paddr)
                branch_shift_pkg::OFF_ACC:   nxt_acc     = pwdata[7:0];
                branch_shift_pkg::OFF_LATCH: nxt_latch   = pwdata[6:0];
                branch_shift_pkg::OFF_FIDX:  nxt_fileIdx = pwdata[6:0];
                branch_shift_pkg::OFF_STATUS:
                begin
                    nxt_null  = pwdata[branch_shift_pkg::STAT_NULL_BIT];
                    nxt_shift = pwdata[branch_shift_pkg::STAT_SHIFT_BIT];
                end
                default:                     nxt_acc     = acc_ff;
            endcase
        end
        if (launch)
        begin
            nxt_instr = pwdata[branch_shift_pkg::INSTR_W-1:0];
        end
        // the jump touches no flag; only single-cycle operations land here
        if (launchOne)                                                        // [RL3]
        begin
            nxt_null = aluZero;                                               // [RL9]
            if (isShift)
            begin
                nxt_shift = aluShift;                                         // [RL7] [RL8]
            end
            if (!toFile)
            begin
                nxt_acc = aluResult;                                          // [RL4] [RL6]
            end
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            acc_ff     <= branch_shift_pkg::RST_ACC;
            latch_ff   <= branch_shift_pkg::RST_LATCH;
            fileIdx_ff <= branch_shift_pkg::RST_FIDX;
            instr_ff   <= branch_shift_pkg::RST_INSTR;
            null_ff    <= 1'b0;
            shift_ff   <= 1'b0;
        end
        else if (clkEn)
        begin
            acc_ff     <= nxt_acc;
            latch_ff   <= nxt_latch;
            fileIdx_ff <= nxt_fileIdx;
            instr_ff   <= nxt_instr;
            null_ff    <= nxt_null;
            shift_ff   <= nxt_shift;
        end
    end

    // register file: one write port shared by software and execution
    always_comb
    begin
        fileWe     = 1'b0;
        fileWeIdx  = fileIdx_ff;
        fileWeData = pwdata[7:0];
        if (wrDone & (paddr == branch_shift_pkg::OFF_FDATA))
        begin
            fileWe = 1'b1;
        end
        else if (launchOne & toFile)
        begin
            fileWe     = 1'b1;                                                // [RL5] [RL6]
            fileWeIdx  = instrIdx;
            fileWeData = aluResult;
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < branch_shift_pkg::FILE_DEPTH; i++)
            begin
                file_ff[i] <= branch_shift_pkg::RST_FILE;
            end
        end
        else if (clkEn & fileWe)
        begin
            file_ff[fileWeIdx] <= fileWeData;
        end
    end

    // apb answer: read data is captured at the same edge that pready rises
    always_comb
    begin
        readMux = '0;
        mapped  = 1'b1;
        unique case (paddr)
            branch_shift_pkg::OFF_INSTR:  readMux[15:0] = instr_ff;
            branch_shift_pkg::OFF_ACC:    readMux[7:0]  = acc_ff;
            branch_shift_pkg::OFF_LATCH:  readMux[6:0]  = latch_ff;
            branch_shift_pkg::OFF_FIDX:   readMux[6:0]  = fileIdx_ff;
            branch_shift_pkg::OFF_FDATA:  readMux[7:0]  = file_ff[fileIdx_ff];
            branch_shift_pkg::OFF_STATUS:
            begin
                readMux[branch_shift_pkg::STAT_NULL_BIT]  = null_ff;
                readMux[branch_shift_pkg::STAT_SHIFT_BIT] = shift_ff;
                readMux[branch_shift_pkg::STAT_BUSY_BIT]  = busy_ff;
            end
            branch_shift_pkg::OFF_PC:     readMux[14:0] = pcValue;
            default:                      mapped        = 1'b0;
        endcase
    end

    // wait states while a jump is still loading keep the next write from overtaking it
    always_comb
    begin
        nxt_pready  = psel & ~pready_ff & ~busy_ff;
        nxt_prdata  = prdata_ff;
        nxt_pslverr = 1'b0;
        if (nxt_pready)
        begin
            nxt_prdata  = pwrite ? '0 : readMux;
            nxt_pslverr = ~mapped |
                          (pwrite & (paddr == branch_shift_pkg::OFF_INSTR) & ~opcodeLegal) |
                          (pwrite & (paddr == branch_shift_pkg::OFF_PC));
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            prdata_ff  <= '0;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else if (clkEn)
        begin
            prdata_ff  <= nxt_prdata;
            pready_ff  <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
        end
    end

    assign prdata         = prdata_ff;
    assign pready         = pready_ff;
    assign pslverr        = pslverr_ff;
    assign progCounter    = pcValue;
    assign accumulator    = acc_ff;
    assign resultNullFlag = null_ff;
    assign shiftOutFlag   = shift_ff;
    assign execBusy       = busy_ff;
endmodule

// ==== common/branch_shift_pkg.sv ====
// Functional notes
// RL1: absolute jump loads the 11-bit literal into program counter bits 10:0.
// RL2: absolute jump fills program counter bits 14:11 from upper jump latch bits 6:3.
// RL3: absolute jump takes two cycles and leaves every status flag untouched.
// RL4: or literal ORs accumulator with 8-bit literal, result to accumulator, null flag.
// RL5: increment adds one to the indexed register, routes by target select, null flag.
// RL6: or file ORs accumulator with register; target 0 accumulator, 1 register; null flag.
// RL7: left shift: bit 7 to shift-out flag, bits 6:0 up, zero into bit 0.
// RL8: right shift: zero into bit 7, bits 7:1 down, bit 0 to shift-out flag.
// RL9: null flag is set when the 8-bit result is zero, cleared otherwise.
// RL10: or, increment and shifts finish in one cycle; program counter then advances by one.
package branch_shift_pkg;
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 8;
    localparam int BYTE_W     = 8;
    localparam int PC_W       = 15;
    localparam int LIT_W      = 11;
    localparam int IDX_W      = 7;
    localparam int LATCH_W    = 7;
    localparam int OPC_W      = 3;
    localparam int INSTR_W    = 16;
    localparam int FILE_DEPTH = 128;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] OFF_INSTR   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_ACC     = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_LATCH   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_FIDX    = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_FDATA   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_PC      = 8'h18;

    // instruction word fields
    localparam int INSTR_LIT_LSB = 0;
    localparam int INSTR_TGT_BIT = 12;
    localparam int INSTR_OPC_LSB = 13;

    // operation codes
    localparam logic [OPC_W-1:0] OPC_JUMP    = 3'h0;
    localparam logic [OPC_W-1:0] OPC_OR_LIT  = 3'h1;
    localparam logic [OPC_W-1:0] OPC_INC     = 3'h2;
    localparam logic [OPC_W-1:0] OPC_OR_FILE = 3'h3;
    localparam logic [OPC_W-1:0] OPC_SHL     = 3'h4;
    localparam logic [OPC_W-1:0] OPC_SHR     = 3'h5;

    // result target select
    localparam logic TGT_ACC  = 1'b0;
    localparam logic TGT_FILE = 1'b1;

    // status register bits
    localparam int STAT_NULL_BIT  = 0;
    localparam int STAT_SHIFT_BIT = 1;
    localparam int STAT_BUSY_BIT  = 2;

    // latch bits that feed the top of the program counter
    localparam int LATCH_JUMP_MSB = 6;
    localparam int LATCH_JUMP_LSB = 3;

    // reset values
    localparam logic [BYTE_W-1:0]  RST_ACC   = 8'h00;
    localparam logic [BYTE_W-1:0]  RST_FILE  = 8'h00;
    localparam logic [LATCH_W-1:0] RST_LATCH = 7'h00;
    localparam logic [IDX_W-1:0]   RST_FIDX  = 7'h00;
    localparam logic [PC_W-1:0]    RST_PC    = 15'h0000;
    localparam logic [INSTR_W-1:0] RST_INSTR = 16'h0000;

    // timing
    localparam int JUMP_CYCLES = 2;
endpackage

// ==== verilog/exec_alu.sv ====
`timescale 1ns/10ps
module exec_alu
(
    // operation select
    input  wire logic [2:0] opcode,
    // operands
    input  wire logic [7:0] accIn,
    input  wire logic [7:0] fileIn,
    input  wire logic [7:0] literal,
    // results
    output logic      [7:0] result,
    output logic            resultZero,
    output logic            shiftBit
);
    always_comb
    begin
        result   = fileIn;
        shiftBit = 1'b0;
        case (opcode)
            branch_shift_pkg::OPC_OR_LIT:  result = accIn | literal;          // [RL4]
            branch_shift_pkg::OPC_INC:     result = fileIn + 8'h01;           // [RL5]
            branch_shift_pkg::OPC_OR_FILE: result = accIn | fileIn;           // [RL6]
            branch_shift_pkg::OPC_SHL:
            begin
                result   = {fileIn[6:0], 1'b0};                               // [RL7]
                shiftBit = fileIn[7];                                         // [RL7]
            end
            branch_shift_pkg::OPC_SHR:
            begin
                result   = {1'b0, fileIn[7:1]};                               // [RL8]
                shiftBit = fileIn[0];                                         // [RL8]
            end
            default:     result = fileIn;
        endcase
        resultZero = (result == 8'h00);                                       // [RL9]
    end
endmodule

// ==== verilog/prog_counter_unit.sv ====
`timescale 1ns/10ps
module prog_counter_unit
(
    // clock and reset
    input  wire logic                              ref_clk,
    input  wire logic                              reset,
    input  wire logic                              clkEn,
    // control
    input  wire logic                              advance,
    input  wire logic                              load,
    input  wire logic [branch_shift_pkg::PC_W-1:0] loadValue,
    // state
    output logic      [branch_shift_pkg::PC_W-1:0] pc_ff
);
    logic [branch_shift_pkg::PC_W-1:0] nxt_pc;

    always_comb
    begin
        nxt_pc = pc_ff;
        if (load)
        begin
            nxt_pc = loadValue;
        end
        else if (advance)
        begin
            nxt_pc = pc_ff + 15'h0001;                                        // [RL10]
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            pc_ff <= branch_shift_pkg::RST_PC;
        end
        else if (clkEn)
        begin
            pc_ff <= nxt_pc;
        end
    end
endmodule

// ==== bench/branch_shift_asserts.sv ====
`timescale 1ns/10ps
module branch_shift_asserts
(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // core state
    input wire logic [14:0] progCounter,
    input wire logic [7:0]  accumulator,
    input wire logic        resultNullFlag,
    input wire logic        shiftOutFlag,
    input wire logic        execBusy
);
    logic       done;
    logic       go;
    logic       jmp;
    logic       toAcc;
    logic [6:0] latch_ff;
    logic [6:0] nxt_latch;

    assign done = psel && penable && pready && pwrite && !pslverr;
    assign go = done && paddr == branch_shift_pkg::OFF_INSTR;
    assign jmp = pwdata[15:13] == branch_shift_pkg::OPC_JUMP;
    // or literal always lands in the accumulator, whatever the target bit says
    assign toAcc = !pwdata[12] || pwdata[15:13] == branch_shift_pkg::OPC_OR_LIT;

    always_comb
    begin
        nxt_latch = latch_ff;
        if (done && paddr == branch_shift_pkg::OFF_LATCH)
            nxt_latch = pwdata[6:0];
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
            latch_ff <= branch_shift_pkg::RST_LATCH;
        else
            latch_ff <= nxt_latch;
    end

    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    AST_JUMP_LOW: assert property (
        go && jmp |-> ##2 progCounter[10:0] == $past(pwdata[10:0], 2))
        else $error("jump low target bits wrong");
    AST_JUMP_HIGH: assert property (
        go && jmp |-> ##2 progCounter[14:11] == $past(latch_ff[6:3], 2))
        else $error("jump high target bits wrong");
    AST_JUMP_BUSY: assert property (
        go && jmp |=> execBusy ##1 !execBusy)
        else $error("jump busy span wrong");
    AST_JUMP_FLAGS: assert property (
        go && jmp |=> ($stable(resultNullFlag) && $stable(shiftOutFlag)) [*2])
        else $error("jump changed a flag");
    AST_OR_LIT: assert property (
        go && pwdata[15:13] == branch_shift_pkg::OPC_OR_LIT
        |=> accumulator == ($past(accumulator) | $past(pwdata[7:0])))
        else $error("or literal result wrong");
    AST_NULL_FLAG: assert property (
        go && !jmp && toAcc |=> resultNullFlag == (accumulator == 8'h00))
        else $error("null flag does not match result");
    AST_FILE_TARGET: assert property (
        go && !jmp && !toAcc |=> $stable(accumulator))
        else $error("file target changed accumulator");
    AST_PC_STEP: assert property (
        go && !jmp |=> progCounter == $past(progCounter) + 15'h0001)
        else $error("program counter did not step by one");
endmodule

// ==== bench/test_branch_or_shift_exec_unit.sv ====
`timescale 1ns/10ps
module test_branch_or_shift_exec_unit;
    logic        ref_clk;
    logic        reset;
    logic        clkEn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [14:0] progCounter;
    logic [7:0]  accumulator;
    logic        resultNullFlag;
    logic        shiftOutFlag;
    logic        execBusy;
    logic [31:0] rd;
    logic        err;
    logic [14:0] pcExp;
    int          n_fail;
    int          n_compared;
    int          seed;

    // clock enable stays high except for one freeze scenario near the end
    branch_or_shift_exec_unit dut_u
    (
        .ref_clk(ref_clk), .reset(reset), .clkEn(clkEn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .progCounter(progCounter), .accumulator(accumulator),
        .resultNullFlag(resultNullFlag), .shiftOutFlag(shiftOutFlag), .execBusy(execBusy)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp);
        chkv({31'h0, got}, {31'h0, exp});
    endtask

    // one idle edge first, so psel is never assigned twice in one time step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1);
        chkb(n < 40, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // shift-out bit in bit 8, result in bits 7:0
    function automatic logic [8:0] calc(input logic [2:0] op, input logic [7:0] acc,
                                        input logic [7:0] f, input logic [7:0] lit);
        case (op)
            branch_shift_pkg::OPC_OR_LIT:  return {1'b0, acc | lit};
            branch_shift_pkg::OPC_INC:     return {1'b0, f + 8'h01};
            branch_shift_pkg::OPC_OR_FILE: return {1'b0, acc | f};
            branch_shift_pkg::OPC_SHL:     return {f[7], f[6:0], 1'b0};
            default:                       return {f[0], 1'b0, f[7:1]};
        endcase
    endfunction

    task automatic run_op(input logic [2:0] op, input logic tgt, input logic [10:0] low,
                          input logic [7:0] acc, input logic [7:0] f,
                          input logic [6:0] latch, input logic [1:0] fl);
        logic [8:0] r;
        logic       jmp;
        logic       toF;
        logic       shf;
        r = calc(op, acc, f, low[7:0]);
        jmp = op == branch_shift_pkg::OPC_JUMP;
        toF = tgt && op != branch_shift_pkg::OPC_OR_LIT && !jmp;
        shf = op == branch_shift_pkg::OPC_SHL || op == branch_shift_pkg::OPC_SHR;
        apb(1'b1, branch_shift_pkg::OFF_ACC, {24'h0, acc});
        apb(1'b1, branch_shift_pkg::OFF_LATCH, {25'h0, latch});
        apb(1'b1, branch_shift_pkg::OFF_FIDX, {25'h0, low[6:0]});
        apb(1'b1, branch_shift_pkg::OFF_FDATA, {24'h0, f});
        apb(1'b1, branch_shift_pkg::OFF_STATUS, {30'h0, fl});
        apb(1'b1, branch_shift_pkg::OFF_INSTR, {16'h0, op, tgt, 1'b0, low});
        pcExp = jmp ? {latch[6:3], low} : pcExp + 15'h0001;
        apb(1'b0, branch_shift_pkg::OFF_FDATA, 32'h0);
        chkv(rd, {24'h0, toF ? r[7:0] : f});
        chkv({17'h0, progCounter}, {17'h0, pcExp});
        chkv({24'h0, accumulator}, {24'h0, (jmp || toF) ? acc : r[7:0]});
        chkb(resultNullFlag, jmp ? fl[0] : r[7:0] == 8'h00);
        chkb(shiftOutFlag, shf ? r[8] : fl[1]);
    endtask

    initial
    begin
        repeat (10000) @(posedge ref_clk);
        n_fail++;
        summarize();
    end

    initial
    begin
        seed = 48;
        n_fail = 0;
        n_compared = 0;
        pcExp = 15'h0000;
        reset = 1'b1;
        clkEn = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        chkv({9'h0, progCounter, accumulator}, 32'h0000_0000);
        chkv({30'h0, resultNullFlag, shiftOutFlag}, 32'h0000_0000);
        $display("test reset done");
        run_op(branch_shift_pkg::OPC_INC, 1'b1, 11'h07F, 8'h5A, 8'hFF, 7'h00, 2'b10);
        run_op(branch_shift_pkg::OPC_INC, 1'b0, 11'h011, 8'h00, 8'h7F, 7'h00, 2'b01);
        run_op(branch_shift_pkg::OPC_SHL, 1'b0, 11'h000, 8'h33, 8'h80, 7'h00, 2'b00);
        run_op(branch_shift_pkg::OPC_SHR, 1'b1, 11'h001, 8'h00, 8'h01, 7'h00, 2'b00);
        run_op(branch_shift_pkg::OPC_OR_LIT, 1'b1, 11'h0FF, 8'h00, 8'h12, 7'h00, 2'b01);
        run_op(branch_shift_pkg::OPC_OR_LIT, 1'b0, 11'h700, 8'h00, 8'h00, 7'h00, 2'b10);
        run_op(branch_shift_pkg::OPC_OR_FILE, 1'b1, 11'h040, 8'hA5, 8'h5A, 7'h00, 2'b11);
        run_op(branch_shift_pkg::OPC_JUMP, 1'b0, 11'h7FF, 8'h01, 8'h02, 7'h78, 2'b11);
        run_op(branch_shift_pkg::OPC_JUMP, 1'b1, 11'h2AA, 8'h00, 8'h00, 7'h67, 2'b01);
        $display("test corners done");
        repeat (40)
            run_op(3'($unsigned($random(seed)) % 6), 1'($random(seed)), 11'($random(seed)),
                   8'($random(seed)), 8'($random(seed)), 7'($random(seed)),
                   2'($random(seed)));
        $display("test random done");
        apb(1'b0, 8'h1C, 32'h0);
        chkv({31'h0, err}, 32'h0000_0001);
        chkv(rd, 32'h0000_0000);
        apb(1'b1, branch_shift_pkg::OFF_PC, 32'h0000_1234);
        chkb(err, 1'b1);
        apb(1'b1, branch_shift_pkg::OFF_INSTR, 32'h0000_C000);
        chkb(err, 1'b1);
        apb(1'b1, branch_shift_pkg::OFF_INSTR, 32'h0000_E000);
        chkb(err, 1'b1);
        chkv({17'h0, progCounter}, {17'h0, pcExp});
        $display("test refusals done");
        // clock enable low holds the handshake: no answer until it returns
        clkEn <= 1'b0;
        fork
            apb(1'b1, branch_shift_pkg::OFF_ACC, 32'h0000_00C3);
            begin
                repeat (4) @(posedge ref_clk);
                chkb(pready, 1'b0);
                clkEn <= 1'b1;
            end
        join
        apb(1'b0, branch_shift_pkg::OFF_ACC, 32'h0);
        chkv(rd, 32'h0000_00C3);
        $display("test freeze done");
        summarize();
    end
endmodule

bind branch_or_shift_exec_unit branch_shift_asserts chk_u
(
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .progCounter(progCounter), .accumulator(accumulator),
    .resultNullFlag(resultNullFlag), .shiftOutFlag(shiftOutFlag), .execBusy(execBusy)
);
